/* rtl/ser_device.sv */
// Functional notes
// - Host holds reset low 0.5 ms lock
// - Plus 32 or 64 extra reset cycles
// - Inputs sampled on double-rate core clock
// - Every register is 72 bits wide
// - Addresses 0-31 read-only comparand pairs
// - Masks at 32-47 and 96-111 read/write
// - Slots 48-55, control 56, device_information 57
// - Burst 58/59, free pointer 60, reserved 61-63
// - Each search stores comparand into one pair
// - Phase A to even, phase B odd
// - Learn uses comparands stored by search
// - Mask index n selects masks 2n, 2n+1
// - Host writes equal masks for 72-bit ops
// - Search mask one compares, zero matches
// - Write mask one writes, zero keeps bit
// - Phase B names destination hit index slot
// - Index updates on hit by winner only
// - Valid bit set only by global winner
// - Indirect access only when valid is set
// - Host may address via stored index
// - Phase A rises high, phase B low
`timescale 1ns/1ps
`default_nettype none
module ser_device
  import ser_pkg::*;
#(
  parameter logic [71:0] DEVICE_INFORMATION_VALUE = 72'h00_0000_0000_0000_0001  // Arbitrary value
) (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_RESETN,
  ser_link_if.device         link,
  input  wire logic          I_RES_VLD,
  input  wire logic          I_RES_HIT,
  input  wire logic          I_LOCAL_WIN,
  input  wire logic          I_GLOBAL_WIN,
  input  wire logic [1:0]    I_RES_SIZE,
  input  wire logic [15:0]   I_RES_INDEX,
  input  wire logic [15:0]   I_FREE_ENTRY,
  output logic               O_SEARCH_REQ,
  output logic               O_LEARN_REQ,
  output logic [143:0]       O_KEY,
  output logic [143:0]       O_KEY_MASK,
  output logic               O_ARRAY_REQ,
  output logic               O_ARRAY_WR,
  output logic [15:0]        O_ARRAY_ADDR,
  output logic [71:0]        O_ARRAY_DATA,
  output logic [71:0]        O_ARRAY_MASK,
  output logic [71:0]        O_CONTROL
);
  logic [71:0]  comp_q [SER_COMP_NUM];
  logic [71:0]  mask_q [SER_MASK_NUM];
  logic [15:0]  idx_q  [SER_SLOT_NUM];
  logic [7:0]   valid_q, valid_d;
  logic         pha_q, pha_d;
  ser_op_t      op_q, op_d;
  logic [6:0]   addr_q, addr_d;
  logic [3:0]   midx_q, midx_d;
  logic [71:0]  dqa_q, dqa_d;
  logic [2:0]   pend_q, pend_d;
  logic [71:0]  ctrl_q, ctrl_d;
  logic [71:0]  brd_q, brd_d;
  logic [71:0]  bwr_q, bwr_d;
  logic [71:0]  rdata_q, rdata_d;
  logic         ack_q, ack_d;
  logic         srch_q, srch_d;
  logic         lrn_q, lrn_d;
  logic [143:0] key_q, key_d;
  logic [143:0] kmask_q, kmask_d;
  logic         areq_q, areq_d;
  logic         awr_q, awr_d;
  logic [15:0]  aaddr_q, aaddr_d;
  logic [71:0]  adata_q, adata_d;
  logic [71:0]  amask_q, amask_d;
  logic         comp_we, mask_we, idx_we;
  logic [4:0]   mask_wsel;
  logic [15:0]  idx_wval;
  logic [4:0]   cpe, cpo, mke, mko;
  assign cpe  = {addr_q[3:0], 1'b0};
  assign cpo  = {addr_q[3:0], 1'b1};
  assign mke  = {midx_q, 1'b0};
  assign mko  = {midx_q, 1'b1};
  function automatic logic [71:0] rd_mux(input logic [6:0] a);
    logic [71:0] v;
    v = SER_ZERO_RST;  // Reserved addresses read zero
    if (a[6:5] == 2'b00) begin
      v = comp_q[a[4:0]];
    end else if (a[5:4] == 2'b10) begin
      v = mask_q[{a[6], a[3:0]}];
    end else if (a[6:3] == 4'b0110) begin
      v[SER_IDX_LSB +: SER_IDX_W] = idx_q[a[2:0]];
      v[SER_VALID_BIT]           = valid_q[a[2:0]];
    end else if (a == SER_CTRL_ADDR) begin
      v = ctrl_q;
    end else if (a == SER_DEVICE_INFORMATION_ADDR) begin
      v = DEVICE_INFORMATION_VALUE;
    end else if (a == SER_BRD_ADDR) begin
      v = brd_q;
    end else if (a == SER_BWR_ADDR) begin
      v = bwr_q;
    end else if (a == SER_NFA_ADDR) begin
      v[15:0] = I_FREE_ENTRY;
    end
    return v;
  endfunction
  always_comb begin
    pha_d     = 1'b0;
    op_d      = op_q;
    addr_d    = addr_q;
    midx_d    = midx_q;
    dqa_d     = dqa_q;
    pend_d    = pend_q;
    ctrl_d    = ctrl_q;
    brd_d     = brd_q;
    bwr_d     = bwr_q;
    rdata_d   = rdata_q;
    ack_d     = 1'b0;
    srch_d    = 1'b0;
    lrn_d     = 1'b0;
    key_d     = key_q;
    kmask_d   = kmask_q;
    areq_d    = 1'b0;
    awr_d     = awr_q;
    aaddr_d   = aaddr_q;
    adata_d   = adata_q;
    amask_d   = amask_q;
    valid_d   = valid_q;
    comp_we   = 1'b0;
    mask_we   = 1'b0;
    mask_wsel = {addr_q[6], addr_q[3:0]};
    idx_we    = 1'b0;
    idx_wval  = I_RES_INDEX;
    // Phase A is taken on a core edge where cmd_vld and the phase marker are high and no phase B is in progress
    if (link.cmd_vld && link.phase_select_low && !pha_q) begin
      pha_d  = 1'b1;
      op_d   = link.op;
      addr_d = link.addr;
      midx_d = link.mask_idx;
      dqa_d  = link.dq_h2d;
    end
    if (pha_q) begin
      case (op_q)
        SER_OP_WR: begin
          if (addr_q[5:4] == 2'b10) begin
            mask_we = 1'b1;
          end else if (addr_q == SER_CTRL_ADDR) begin
            ctrl_d = dqa_q;
          end else if (addr_q == SER_BRD_ADDR) begin
            brd_d = dqa_q;
          end else if (addr_q == SER_BWR_ADDR) begin
            bwr_d = dqa_q;  // Read-only and reserved writes dropped
          end
        end
        SER_OP_RD: begin
          rdata_d = rd_mux(addr_q);
          ack_d   = 1'b1;
        end
        SER_OP_SEARCH: begin
          comp_we = 1'b1;
          key_d   = {dqa_q, link.dq_h2d};
          kmask_d = {mask_q[mke], mask_q[mko]};
          srch_d  = 1'b1;
          pend_d  = link.slot;
        end
        SER_OP_LEARN: begin
          key_d = {comp_q[cpe], comp_q[cpo]};
          lrn_d = 1'b1;
        end
        SER_OP_IND_RD, SER_OP_IND_WR: begin
          if (valid_q[addr_q[2:0]]) begin
            areq_d  = 1'b1;
            awr_d   = (op_q == SER_OP_IND_WR);
            aaddr_d = idx_q[addr_q[2:0]];
            adata_d = dqa_q;
            amask_d = mask_q[mke];
          end
        end
        default: ;
      endcase
    end
    if (I_RES_VLD && I_RES_HIT && (I_LOCAL_WIN || I_GLOBAL_WIN)) begin
      idx_we = 1'b1;
      valid_d[pend_q] = valid_q[pend_q] | I_GLOBAL_WIN;
      case (ser_size_t'(I_RES_SIZE))
        SER_SZ_144: idx_wval = {I_RES_INDEX[15:1], 1'b0};
        SER_SZ_288: idx_wval = {I_RES_INDEX[15:2], 2'b00};
        default:    idx_wval = I_RES_INDEX;
      endcase
    end
    if (!link.rst_n) begin
      valid_d = 8'h00;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      valid_q <= 8'h00;
      pha_q   <= 1'b0;
      op_q    <= SER_OP_NOP;
      addr_q  <= 7'h00;
      midx_q  <= 4'h0;
      dqa_q   <= SER_ZERO_RST;
      pend_q  <= 3'h0;
      ctrl_q  <= SER_CTRL_RST;
      brd_q   <= SER_ZERO_RST;
      bwr_q   <= SER_ZERO_RST;
      rdata_q <= SER_ZERO_RST;
      ack_q   <= 1'b0;
      srch_q  <= 1'b0;
      lrn_q   <= 1'b0;
      key_q   <= {SER_ZERO_RST, SER_ZERO_RST};
      kmask_q <= {SER_ZERO_RST, SER_ZERO_RST};
      areq_q  <= 1'b0;
      awr_q   <= 1'b0;
      aaddr_q <= 16'h0000;
      adata_q <= SER_ZERO_RST;
      amask_q <= SER_ZERO_RST;
    end else begin
      valid_q <= valid_d;
      pha_q   <= pha_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      midx_q  <= midx_d;
      dqa_q   <= dqa_d;
      pend_q  <= pend_d;
      ctrl_q  <= ctrl_d;
      brd_q   <= brd_d;
      bwr_q   <= bwr_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      srch_q  <= srch_d;
      lrn_q   <= lrn_d;
      key_q   <= key_d;
      kmask_q <= kmask_d;
      areq_q  <= areq_d;
      awr_q   <= awr_d;
      aaddr_q <= aaddr_d;
      adata_q <= adata_d;
      amask_q <= amask_d;
    end
  end
  // Storage arrays keep no reset; contents are undefined until first written
  always_ff @(posedge I_CORE_CLK) begin
    if (comp_we) begin
      comp_q[cpe] <= dqa_q;
      comp_q[cpo] <= link.dq_h2d;
    end
    if (mask_we) begin
      mask_q[mask_wsel] <= dqa_q;
    end
    if (idx_we) begin
      idx_q[pend_q] <= idx_wval;
    end
  end

  assign link.dq_d2h    = rdata_q;
  assign link.dq_d2h_oe = ack_q;
  assign link.ack       = ack_q;
  assign O_SEARCH_REQ   = srch_q;
  assign O_LEARN_REQ    = lrn_q;
  assign O_KEY          = key_q;
  assign O_KEY_MASK     = kmask_q;
  assign O_ARRAY_REQ    = areq_q;
  assign O_ARRAY_WR     = awr_q;
  assign O_ARRAY_ADDR   = aaddr_q;
  assign O_ARRAY_DATA   = adata_q;
  assign O_ARRAY_MASK   = amask_q;
  assign O_CONTROL      = ctrl_q;
endmodule
`default_nettype wire

/* rtl/ser_pkg.sv */
package ser_pkg;
  localparam int SER_DATA_W     = 72;
  localparam int SER_ADDR_W     = 7;
  localparam int SER_IDX_W      = 16;
  localparam int SER_COMP_NUM   = 32;
  localparam int SER_MASK_NUM   = 32;
  localparam int SER_SLOT_NUM   = 8;
  localparam int SER_SLOT_W     = 3;
  localparam int SER_MIDX_W     = 4;

  // Register map, word addresses on the command bus
  localparam logic [6:0] SER_COMP_BASE    = 7'h00;
  localparam logic [6:0] SER_MASK_LO_BASE = 7'h20;
  localparam logic [6:0] SER_MASK_HI_BASE = 7'h60;
  localparam logic [6:0] SER_SLOT_BASE    = 7'h30;
  localparam logic [6:0] SER_CTRL_ADDR    = 7'h38;
  localparam logic [6:0] SER_DEVICE_INFORMATION_ADDR    = 7'h39;
  localparam logic [6:0] SER_BRD_ADDR     = 7'h3a;
  localparam logic [6:0] SER_BWR_ADDR     = 7'h3b;
  localparam logic [6:0] SER_NFA_ADDR     = 7'h3c;

  // Hit index slot layout
  localparam int SER_IDX_LSB   = 0;
  localparam int SER_VALID_BIT = 31;

  // Reset values
  localparam logic [71:0] SER_CTRL_RST = 72'h00_0000_0000_0000_0004;
  localparam logic [71:0] SER_ZERO_RST = 72'h00_0000_0000_0000_0000;

  // Power-up timing
  localparam real SER_PLL_LOCK_MS  = 0.5;
  localparam int  SER_CLK_MHZ      = 200;
  localparam int  SER_PLL_LOCK_CYC = int'($ceil(SER_PLL_LOCK_MS * 1000.0 * real'(SER_CLK_MHZ)));
  localparam int  SER_EXTRA_1X     = 32;
  localparam int  SER_EXTRA_2X     = 64;

  typedef enum logic [2:0] {
    SER_OP_NOP,
    SER_OP_RD,
    SER_OP_WR,
    SER_OP_SEARCH,
    SER_OP_LEARN,
    SER_OP_IND_RD,
    SER_OP_IND_WR
  } ser_op_t;

  typedef enum logic [1:0] {
    SER_SZ_72,
    SER_SZ_144,
    SER_SZ_288
  } ser_size_t;
endpackage

/* rtl/ser_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ser_link_if;
  import ser_pkg::*;
  logic          rst_n;
  logic          cmd_vld;
  logic          phase_select_low;
  ser_op_t       op;
  logic [6:0]    addr;
  logic [3:0]    mask_idx;
  logic [2:0]    slot;
  logic [71:0]   dq_h2d;
  logic          dq_h2d_oe;
  logic [71:0]   dq_d2h;
  logic          dq_d2h_oe;
  logic          ack;

  modport device (
    input  rst_n, cmd_vld, phase_select_low, op, addr, mask_idx, slot, dq_h2d, dq_h2d_oe,
    output dq_d2h, dq_d2h_oe, ack
  );
  modport host (
    output rst_n, cmd_vld, phase_select_low, op, addr, mask_idx, slot, dq_h2d, dq_h2d_oe,
    input  dq_d2h, dq_d2h_oe, ack
  );
endinterface
`default_nettype wire

/* rtl/ser_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ser_host
  import ser_pkg::*;
#(
  parameter int LOCK_CYC  = SER_PLL_LOCK_CYC,
  parameter int EXTRA_CYC = SER_EXTRA_2X
) (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_RESETN,
  ser_link_if.host           link,
  input  wire logic          I_REQ,
  input  wire logic [2:0]    I_OP,
  input  wire logic [6:0]    I_ADDR,
  input  wire logic [3:0]    I_MASK_IDX,
  input  wire logic [2:0]    I_SLOT,
  input  wire logic [71:0]   I_DATA_A,
  input  wire logic [71:0]   I_DATA_B,
  output logic               O_READY,
  output logic               O_INIT_DONE,
  output logic [71:0]        O_RDATA,
  output logic               O_RVALID
);
  typedef enum logic [2:0] {SER_H_RST, SER_H_IDLE, SER_H_PHA, SER_H_PHB, SER_H_RDW} ser_hst_t;

  localparam logic [19:0] RST_LAST = 20'(LOCK_CYC + EXTRA_CYC - 1);

  ser_hst_t     st_q, st_d;
  logic [19:0]  cnt_q, cnt_d;
  logic         rstn_q, rstn_d;
  logic         vld_q, vld_d;
  logic         phs_q, phs_d;
  ser_op_t      op_q, op_d;
  logic [6:0]   addr_q, addr_d;
  logic [3:0]   midx_q, midx_d;
  logic [2:0]   slot_q, slot_d;
  logic [71:0]  dq_q, dq_d;
  logic         oe_q, oe_d;
  logic [71:0]  datb_q, datb_d;
  logic [2:0]   slotb_q, slotb_d;
  logic         rdy_q, rdy_d;
  logic [71:0]  rd_q, rd_d;
  logic         rv_q, rv_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    rstn_d  = rstn_q;
    vld_d   = 1'b0;
    phs_d   = 1'b0;
    op_d    = op_q;
    addr_d  = addr_q;
    midx_d  = midx_q;
    slot_d  = slot_q;
    dq_d    = dq_q;
    oe_d    = 1'b0;
    datb_d  = datb_q;
    slotb_d = slotb_q;
    rd_d    = rd_q;
    rv_d    = 1'b0;
    case (st_q)
      SER_H_RST: begin
        // Device reset held through lock time plus the extra cycles
        if (cnt_q == RST_LAST) begin
          rstn_d = 1'b1;
          st_d   = SER_H_IDLE;
        end else begin
          cnt_d = cnt_q + 20'd1;
        end
      end
      SER_H_IDLE: begin
        if (I_REQ) begin
          vld_d   = 1'b1;
          phs_d   = 1'b1;
          op_d    = ser_op_t'(I_OP);
          addr_d  = I_ADDR;
          midx_d  = I_MASK_IDX;
          dq_d    = I_DATA_A;
          oe_d    = 1'b1;
          datb_d  = I_DATA_B;
          slotb_d = I_SLOT;
          st_d    = SER_H_PHA;
        end
      end
      SER_H_PHA: begin
        slot_d = slotb_q;
        dq_d   = datb_q;
        oe_d   = 1'b1;
        st_d   = SER_H_PHB;
      end
      SER_H_PHB: begin
        st_d = (op_q == SER_OP_RD) ? SER_H_RDW : SER_H_IDLE;
      end
      SER_H_RDW: begin
        if (link.ack) begin
          rd_d = link.dq_d2h;
          rv_d = 1'b1;
          st_d = SER_H_IDLE;
        end
      end
      default: begin
        st_d = SER_H_IDLE;
      end
    endcase
    rdy_d = (st_d == SER_H_IDLE);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q    <= SER_H_RST;
      cnt_q   <= 20'd0;
      rstn_q  <= 1'b0;
      vld_q   <= 1'b0;
      phs_q   <= 1'b0;
      op_q    <= SER_OP_NOP;
      addr_q  <= 7'h00;
      midx_q  <= 4'h0;
      slot_q  <= 3'h0;
      dq_q    <= SER_ZERO_RST;
      oe_q    <= 1'b0;
      datb_q  <= SER_ZERO_RST;
      slotb_q <= 3'h0;
      rdy_q   <= 1'b0;
      rd_q    <= SER_ZERO_RST;
      rv_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      rstn_q  <= rstn_d;
      vld_q   <= vld_d;
      phs_q   <= phs_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      midx_q  <= midx_d;
      slot_q  <= slot_d;
      dq_q    <= dq_d;
      oe_q    <= oe_d;
      datb_q  <= datb_d;
      slotb_q <= slotb_d;
      rdy_q   <= rdy_d;
      rd_q    <= rd_d;
      rv_q    <= rv_d;
    end
  end

  assign link.rst_n            = rstn_q;
  assign link.cmd_vld          = vld_q;
  assign link.phase_select_low = phs_q;
  assign link.op               = op_q;
  assign link.addr             = addr_q;
  assign link.mask_idx         = midx_q;
  assign link.slot             = slot_q;
  assign link.dq_h2d           = dq_q;
  assign link.dq_h2d_oe        = oe_q;
  assign O_READY               = rdy_q;
  assign O_INIT_DONE           = rstn_q;
  assign O_RDATA               = rd_q;
  assign O_RVALID              = rv_q;
endmodule
`default_nettype wire

/* verif/ser_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ser_link_assertions
  import ser_pkg::*;
#(
  parameter int LOCK_CYC  = SER_PLL_LOCK_CYC,
  parameter int EXTRA_CYC = SER_EXTRA_2X
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RESETN,
  input wire logic       rst_n,
  input wire logic       cmd_vld,
  input wire logic       phase_select_low,
  input wire logic [2:0] op,
  input wire logic       dq_h2d_oe,
  input wire logic       dq_d2h_oe,
  input wire logic       ack
);
  int unsigned low_cnt_q;
  int unsigned low_cnt_d;

  // Counts edges with the device still held in reset
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (!rst_n) begin
      low_cnt_d = low_cnt_q + 1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      low_cnt_q <= 0;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence rd_take;
    cmd_vld && op == SER_OP_RD;
  endsequence
  sequence rd_reply;
    !ack ##1 (ack && dq_d2h_oe);
  endsequence

  AST_PHASE_A_MARK: assert property (cmd_vld |-> phase_select_low)
    else $error("command marker outside phase A");
  AST_PHASE_B_LOW: assert property (cmd_vld |=> !phase_select_low && !cmd_vld)
    else $error("phase B not low after phase A");
  AST_SEARCH_DQ: assert property (cmd_vld && op == SER_OP_SEARCH |-> dq_h2d_oe ##1 dq_h2d_oe)
    else $error("search data not driven in both phases");
  AST_RD_ANSWER: assert property (rd_take |=> rd_reply)
    else $error("read answer not in cycle after phase B");
  AST_ACK_ONE: assert property (ack |=> !ack)
    else $error("acknowledge longer than one cycle");
  AST_OE_WITH_ACK: assert property (dq_d2h_oe |-> ack)
    else $error("read data driven without acknowledge");
  AST_WR_SILENT: assert property (cmd_vld && op == SER_OP_WR |-> !ack ##1 !ack ##1 !ack)
    else $error("acknowledge after a write");
  AST_INIT_QUIET: assert property (!rst_n |-> !cmd_vld)
    else $error("command issued during device reset");
  AST_INIT_LEN: assert property ($rose(rst_n) |-> low_cnt_q >= LOCK_CYC + EXTRA_CYC)
    else $error("device reset released too early");
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ser_pkg::*;
  localparam int LOCK = 10;
  localparam int EXTRA = 64;
  localparam logic [71:0] DEVICE_INFORMATION = 72'h00_0000_0000_0000_00C3;  // Arbitrary value
  localparam logic [71:0] M6 = 72'hF0_FFFF_0000_FFFF_00FF;
  localparam logic [71:0] M7 = 72'h0F_0000_FFFF_0000_FF00;
  localparam logic [71:0] M18 = 72'h12_3456_789A_BCDE_F012;
  localparam logic [71:0] CA = 72'hA5_5A5A_1234_0000_FFFF;
  localparam logic [71:0] CB = 72'h3C_C3C3_8765_FFFF_0001;
  logic          clk;
  logic          rstn;
  logic          req;
  logic [2:0]    op;
  logic [6:0]    addr;
  logic [3:0]    midx;
  logic [2:0]    slot;
  logic [71:0]   da, db, rdata, got, adata, amask, ctrl;
  logic          ready, done, rvalid, srq, lrq, arq, awr;
  logic          res_vld, res_hit, lwin, gwin;
  logic [1:0]    rsize;
  logic [15:0]   ridx, free, aaddr;
  logic [143:0]  key, kmask;
  int            mismatches = 0;
  int            n_compared = 0;
  int            n_srch = 0;
  int            n_lrn = 0;
  int            n_arr = 0;

  ser_link_if link ();
  ser_device #(.DEVICE_INFORMATION_VALUE(DEVICE_INFORMATION)) ser_device_inst (.I_CORE_CLK(clk), .I_RESETN(rstn),
    .link(link), .I_RES_VLD(res_vld), .I_RES_HIT(res_hit), .I_LOCAL_WIN(lwin),
    .I_GLOBAL_WIN(gwin), .I_RES_SIZE(rsize), .I_RES_INDEX(ridx), .I_FREE_ENTRY(free),
    .O_SEARCH_REQ(srq), .O_LEARN_REQ(lrq), .O_KEY(key), .O_KEY_MASK(kmask), .O_ARRAY_REQ(arq),
    .O_ARRAY_WR(awr), .O_ARRAY_ADDR(aaddr), .O_ARRAY_DATA(adata), .O_ARRAY_MASK(amask),
    .O_CONTROL(ctrl));
  ser_host #(.LOCK_CYC(LOCK), .EXTRA_CYC(EXTRA)) ser_host_inst (.I_CORE_CLK(clk),
    .I_RESETN(rstn), .link(link), .I_REQ(req), .I_OP(op), .I_ADDR(addr), .I_MASK_IDX(midx),
    .I_SLOT(slot), .I_DATA_A(da), .I_DATA_B(db), .O_READY(ready), .O_INIT_DONE(done),
    .O_RDATA(rdata), .O_RVALID(rvalid));
  ser_link_assertions #(.LOCK_CYC(LOCK), .EXTRA_CYC(EXTRA)) ser_link_assertions_inst (
    .I_CORE_CLK(clk), .I_RESETN(rstn), .rst_n(link.rst_n), .cmd_vld(link.cmd_vld),
    .phase_select_low(link.phase_select_low), .op(link.op), .dq_h2d_oe(link.dq_h2d_oe),
    .dq_d2h_oe(link.dq_d2h_oe), .ack(link.ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (srq === 1'b1) n_srch++;
    if (lrq === 1'b1) n_lrn++;
    if (arq === 1'b1) n_arr++;
  end

  task automatic report(input logic [143:0] g, input logic [143:0] e);
    mismatches++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic chk_w(input logic [143:0] g, input logic [143:0] e);
    n_compared++;
    if (g !== e) report(g, e);
  endtask
  task automatic chk_b(input logic g, input logic e);
    n_compared++;
    if (g !== e) report({143'h0, g}, {143'h0, e});
  endtask
  task automatic chk_n(input int g, input int e);
    n_compared++;
    if (g != e) report(144'(g), 144'(e));
  endtask

  task automatic cmd(input ser_op_t o, input logic [6:0] a, input logic [3:0] m,
                     input logic [2:0] s, input logic [71:0] x, input logic [71:0] y);
    int k;
    k = 0;
    @(posedge clk);
    while (ready !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk_b(ready, 1'b1);
    req <= 1'b1;
    {op, addr, midx, slot, da, db} <= {o, a, m, s, x, y};
    @(posedge clk);
    req <= 1'b0;
    if (o == SER_OP_RD) begin
      k = 0;
      while (rvalid !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      chk_b(rvalid, 1'b1);
      got = rdata;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [71:0] e);
    cmd(SER_OP_RD, a, 4'h0, 3'h0, 72'h0, 72'h0);
    chk_w({72'h0, got}, {72'h0, e});
  endtask
  task automatic res(input logic h, input logic l, input logic g, input logic [1:0] z,
                     input logic [15:0] i);
    repeat (4) @(posedge clk);
    {res_vld, res_hit, lwin, gwin, rsize, ridx} <= {1'b1, h, l, g, z, i};
    @(posedge clk);
    res_vld <= 1'b0;
  endtask

  task automatic t_init();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk_b(done, 1'b1);
    chk_b(k >= LOCK + EXTRA, 1'b1);
  endtask
  task automatic t_regs();
    cmd(SER_OP_WR, 7'h26, 4'h0, 3'h0, M6, 72'h0);
    cmd(SER_OP_WR, 7'h27, 4'h0, 3'h0, M7, 72'h0);
    cmd(SER_OP_WR, 7'h62, 4'h0, 3'h0, M18, 72'h0);
    cmd(SER_OP_WR, 7'h63, 4'h0, 3'h0, M18, 72'h0);
    rd(7'h62, M18);
    rd(7'h26, M6);
    cmd(SER_OP_WR, SER_CTRL_ADDR, 4'h0, 3'h0, 72'h00_0000_0000_0000_0006, 72'h0);
    rd(SER_CTRL_ADDR, 72'h00_0000_0000_0000_0006);
    chk_w({72'h0, ctrl}, {72'h0, 72'h00_0000_0000_0000_0006});
    cmd(SER_OP_WR, SER_DEVICE_INFORMATION_ADDR, 4'h0, 3'h0, ~72'h0, 72'h0);
    rd(SER_DEVICE_INFORMATION_ADDR, DEVICE_INFORMATION);
    rd(SER_NFA_ADDR, {56'h0, free});
    cmd(SER_OP_WR, SER_BRD_ADDR, 4'h0, 3'h0, CA, 72'h0);
    rd(SER_BRD_ADDR, CA);
    cmd(SER_OP_WR, SER_BWR_ADDR, 4'h0, 3'h0, CB, 72'h0);
    rd(SER_BWR_ADDR, CB);
    cmd(SER_OP_WR, 7'h3d, 4'h0, 3'h0, ~72'h0, 72'h0);
    rd(7'h3d, 72'h0);
  endtask
  task automatic t_search();
    cmd(SER_OP_SEARCH, 7'h05, 4'h3, 3'h2, CA, CB);
    rd(7'h0a, CA);
    rd(7'h0b, CB);
    chk_n(n_srch, 1);
    chk_w(key, {CA, CB});
    chk_w(kmask, {M6, M7});
    cmd(SER_OP_WR, 7'h0a, 4'h0, 3'h0, ~72'h0, 72'h0);
    rd(7'h0a, CA);
    res(1'b1, 1'b0, 1'b1, SER_SZ_144, 16'h1235);
    rd(7'h32, 72'h00_0000_0000_8000_1234);
    cmd(SER_OP_SEARCH, 7'h01, 4'h3, 3'h5, CB, CA);
    rd(7'h02, CB);
    res(1'b1, 1'b1, 1'b0, SER_SZ_72, 16'h0040);
    rd(7'h35, 72'h00_0000_0000_0000_0040);
    rd(7'h32, 72'h00_0000_0000_8000_1234);
    res(1'b0, 1'b1, 1'b1, SER_SZ_72, 16'h7777);
    rd(7'h35, 72'h00_0000_0000_0000_0040);
    res(1'b1, 1'b1, 1'b1, SER_SZ_288, 16'h0107);
    rd(7'h35, 72'h00_0000_0000_8000_0104);
    chk_n(n_srch, 2);
    cmd(SER_OP_RD, 7'h34, 4'h0, 3'h0, 72'h0, 72'h0);
    chk_w({88'h0, got[71:16]}, 144'h0);
  endtask
  task automatic t_learn_ind();
    cmd(SER_OP_LEARN, 7'h05, 4'h3, 3'h0, 72'h0, 72'h0);
    repeat (4) @(posedge clk);
    chk_n(n_lrn, 1);
    chk_w(key, {CA, CB});
    cmd(SER_OP_IND_RD, 7'h05, 4'h0, 3'h0, 72'h0, 72'h0);
    repeat (4) @(posedge clk);
    chk_n(n_arr, 1);
    chk_b(awr, 1'b0);
    chk_w({128'h0, aaddr}, {128'h0, 16'h0104});
    cmd(SER_OP_IND_RD, 7'h04, 4'h0, 3'h0, 72'h0, 72'h0);
    repeat (4) @(posedge clk);
    chk_n(n_arr, 1);
    cmd(SER_OP_IND_WR, 7'h02, 4'h9, 3'h0, CA, CA);
    repeat (4) @(posedge clk);
    chk_n(n_arr, 2);
    chk_b(awr, 1'b1);
    chk_w({128'h0, aaddr}, {128'h0, 16'h1234});
    chk_w({72'h0, adata}, {72'h0, CA});
    chk_w({72'h0, amask}, {72'h0, M18});
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    req = 1'b0;
    {op, addr, midx, slot, da, db} = '0;
    {res_vld, res_hit, lwin, gwin, rsize, ridx} = '0;
    free = 16'hBEEF;
    repeat (2) @(posedge clk);
    chk_b(done, 1'b0);
    rstn <= 1'b1;
    t_init();
    t_regs();
    t_search();
    t_learn_ind();
    final_report();
  end
endmodule
`default_nettype wire
